// >>> pkg/intra_pred_map.vh
// register offsets, field positions and fixed values of the intra predictor
`ifndef INTRA_PRED_MAP_VH
`define INTRA_PRED_MAP_VH
// ****************************************
// register offsets (byte addresses)
// ****************************************
`define OFS_NEIGH 12'h000
`define OFS_MODE 12'h004
`define OFS_MBTYPE 12'h008
`define OFS_STATUS 12'h00C
`define OFS_COEF 12'h010
`define OFS_DC_OUT 12'h014
`define OFS_AVAIL 12'h018
`define OFS_CORNER 12'h01C
`define OFS_CSUM_AB 12'h020
`define OFS_CSUM_LF 12'h024
`define OFS_CPRED 12'h028
`define OFS_ABOVE 12'h100
`define OFS_LEFT 12'h140
`define OFS_PRED 12'h400
// ****************************************
// field positions and values
// ****************************************
`define NB_OUTSIDE 4'h9
`define CLS_NORMAL 2'h0
`define CLS_OUTSIDE 2'h1
`define CLS_INTRA16 2'h2
`define CLS_INTER 2'h3
`define NEIGH_RESET 32'h00000000
`define MBTYPE_RESET 5'h01
`define FLAT_SAMPLE 8'h80
`define DC_COUNT 9'h010
`define AC_COUNT 9'h0F0
`define DC_SCALE 32'h00000030
`define DC_SHIFT 15
`define DC_GAIN 32'h000000A9
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> src/intra_pred.v
// intra predictor: 4x4 mode ordering, 16x16 luma, 8x8 chroma, dc handling, axi4-lite
//
// Function
// RL1 - 4x4 mode is the rank-th entry of the list chosen by left and above modes
// RL2 - 16x16 block indexed 0..15; above row and left column are the neighbours
// RL3 - mode 0: each column copies its above neighbour
// RL4 - mode 1: each row copies its left neighbour
// RL5 - mode 2: all samples are sum of 32 neighbours divided by 32
// RL6 - mode 2: only one group of 16 present, use its average
// RL7 - mode 2: no neighbours present, all samples are 128
// RL8 - mode 3: (a + b(i-7) + c(j-7) + 16)/32 clamped to 0..255
// RL9 - a = 16(bottom-left + top-right); b, c = 5(H/4)/16, 5(V/4)/16
// RL10 - a second 4x4 transform runs over the sixteen dc coefficients; only its dc term is computed
// RL11 - dc coefficients scaled by 48 / 2^15 instead of divided by 676; the code also multiplies by DC_GAIN (169)
// RL12 - sixteen dc coefficients first; fifteen ac per block only when flagged
// RL13 - a single scan order serves 16x16 intra coefficients
// RL14 - macroblock type code gives mode, ac flag and chroma pattern
// RL15 - chroma uses one mode; quadrants predicted from four neighbour sums
// RL16 - all sums present: (S0+S2+4)/8, (S1+2)/4, (S3+2)/4, (S1+S3+4)/8
// RL17 - above sums only: left quadrants (S0+2)/4, right quadrants (S1+2)/4
// RL18 - left sums only: top quadrants (S2+2)/4, bottom quadrants (S3+2)/4
// RL19 - no sums present: all chroma quadrants are 128
// RL20 - 16x16 neighbour counts as mode 0; inter as 0 or outside if constrained
// RL21 - divisions truncate, signed arithmetic wide enough for plane sums
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "intra_pred_map.vh"

module intra_pred (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // ****************************************
  // state
  // ****************************************
  reg [7:0] above_mem [0:15];
  reg [7:0] left_mem [0:15];
  reg signed [15:0] dc_coef [0:15];
  reg [31:0] neigh_reg;
  reg [4:0] macroblock_type_code;
  reg [3:0] avail_reg;
  reg [7:0] corner_reg;
  reg [9:0] chroma_sum_above_left;
  reg [9:0] chroma_sum_above_right;
  reg [9:0] chroma_sum_left_top;
  reg [9:0] chroma_sum_left_bottom;
  reg [8:0] coef_cnt_reg;
  reg coef_over_reg;
  reg [3:0] mode_reg;
  reg [31:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg aw_full_reg;
  reg w_full_reg;
  integer k, kl, kd;

  // ****************************************
  // mode ordering lookup
  // ****************************************
  // packed nine hex digits, most probable first; short lists padded with 0
  function [35:0] ord_lookup;
    input [7:0] ba;
    begin
      case (ba)
        8'h99: ord_lookup = 36'h000000000;
        8'h90: ord_lookup = 36'h010000000;
        8'h91: ord_lookup = 36'h100000000;
        8'h09: ord_lookup = 36'h020000000;
        8'h29: ord_lookup = 36'h200000000;
        8'h00: ord_lookup = 36'h021648573;
        8'h01: ord_lookup = 36'h125630487;
        8'h02: ord_lookup = 36'h021876543;
        8'h03: ord_lookup = 36'h021358647;
        8'h04: ord_lookup = 36'h206147583;
        8'h05: ord_lookup = 36'h512368047;
        8'h06: ord_lookup = 36'h162054378;
        8'h07: ord_lookup = 36'h204761853;
        8'h08: ord_lookup = 36'h208134657;
        8'h10: ord_lookup = 36'h102654387;
        8'h11: ord_lookup = 36'h162530487;
        8'h12: ord_lookup = 36'h120657483;
        8'h13: ord_lookup = 36'h102536487;
        8'h14: ord_lookup = 36'h162045378;
        8'h15: ord_lookup = 36'h156320487;
        8'h16: ord_lookup = 36'h165423078;
        8'h17: ord_lookup = 36'h612047583;
        8'h18: ord_lookup = 36'h120685734;
        8'h20: ord_lookup = 36'h280174365;
        8'h21: ord_lookup = 36'h217683504;
        8'h22: ord_lookup = 36'h287106435;
        8'h23: ord_lookup = 36'h281035764;
        8'h24: ord_lookup = 36'h287640153;
        8'h25: ord_lookup = 36'h215368740;
        8'h26: ord_lookup = 36'h216748530;
        8'h27: ord_lookup = 36'h278016435;
        8'h28: ord_lookup = 36'h287103654;
        8'h30: ord_lookup = 36'h201385476;
        8'h31: ord_lookup = 36'h125368470;
        8'h32: ord_lookup = 36'h208137546;
        8'h33: ord_lookup = 36'h325814670;
        8'h34: ord_lookup = 36'h421068357;
        8'h35: ord_lookup = 36'h531268470;
        8'h36: ord_lookup = 36'h216584307;
        8'h37: ord_lookup = 36'h240831765;
        8'h38: ord_lookup = 36'h832510476;
        8'h40: ord_lookup = 36'h201467835;
        8'h41: ord_lookup = 36'h162045873;
        8'h42: ord_lookup = 36'h204178635;
        8'h43: ord_lookup = 36'h420615837;
        8'h44: ord_lookup = 36'h426015783;
        8'h45: ord_lookup = 36'h162458037;
        8'h46: ord_lookup = 36'h641205783;
        8'h47: ord_lookup = 36'h427061853;
        8'h48: ord_lookup = 36'h204851763;
        8'h50: ord_lookup = 36'h015263847;
        8'h51: ord_lookup = 36'h152638407;
        8'h52: ord_lookup = 36'h201584673;
        8'h53: ord_lookup = 36'h531286407;
        8'h54: ord_lookup = 36'h125063478;
        8'h55: ord_lookup = 36'h513620847;
        8'h56: ord_lookup = 36'h165230487;
        8'h57: ord_lookup = 36'h210856743;
        8'h58: ord_lookup = 36'h210853647;
        8'h60: ord_lookup = 36'h016247583;
        8'h61: ord_lookup = 36'h160245738;
        8'h62: ord_lookup = 36'h206147853;
        8'h63: ord_lookup = 36'h160245837;
        8'h64: ord_lookup = 36'h640127538;
        8'h65: ord_lookup = 36'h165204378;
        8'h66: ord_lookup = 36'h614027538;
        8'h67: ord_lookup = 36'h264170583;
        8'h68: ord_lookup = 36'h216084573;
        8'h70: ord_lookup = 36'h270148635;
        8'h71: ord_lookup = 36'h217608543;
        8'h72: ord_lookup = 36'h278105463;
        8'h73: ord_lookup = 36'h270154863;
        8'h74: ord_lookup = 36'h274601853;
        8'h75: ord_lookup = 36'h271650834;
        8'h76: ord_lookup = 36'h274615083;
        8'h77: ord_lookup = 36'h274086153;
        8'h78: ord_lookup = 36'h278406153;
        8'h80: ord_lookup = 36'h280173456;
        8'h81: ord_lookup = 36'h127834560;
        8'h82: ord_lookup = 36'h287104365;
        8'h83: ord_lookup = 36'h283510764;
        8'h84: ord_lookup = 36'h287461350;
        8'h85: ord_lookup = 36'h251368407;
        8'h86: ord_lookup = 36'h216847350;
        8'h87: ord_lookup = 36'h287410365;
        8'h88: ord_lookup = 36'h283074165;
        default: ord_lookup = 36'h000000000;
      endcase
    end
  endfunction

  // neighbour class folding into the lookup key
  function [3:0] eff_mode;
    input [3:0] mode;
    input [1:0] cls;
    input cons;
    begin
      case (cls)
        `CLS_OUTSIDE: eff_mode = `NB_OUTSIDE;
        `CLS_INTRA16: eff_mode = 4'h0; // RL20
        `CLS_INTER: eff_mode = cons ? `NB_OUTSIDE : 4'h0; // RL20
        default: eff_mode = (mode > 4'h8) ? 4'h0 : mode;
      endcase
    end
  endfunction

  // ****************************************
  // 4x4 mode selection
  // ****************************************
  wire [3:0] key_left = eff_mode(neigh_reg[3:0], neigh_reg[9:8], neigh_reg[12]);
  wire [3:0] key_above = eff_mode(neigh_reg[7:4], neigh_reg[11:10], neigh_reg[12]);
  wire [3:0] rank = neigh_reg[19:16];
  wire [35:0] ord_list = ord_lookup({key_above, key_left});
  wire [35:0] ord_shift = ord_list >> {(4'h8 - rank), 2'b00};
  wire [3:0] mode_next = (rank > 4'h8) ? 4'h0 : ord_shift[3:0]; // RL1

  // ****************************************
  // macroblock type decode
  // ****************************************
  // code 0 is not 16x16 intra; codes above 24 clamp to the top entry
  wire [4:0] type_idx = (macroblock_type_code == 5'h00) ? 5'h00 :
                        (macroblock_type_code > 5'h18) ? 5'h17 :
                        (macroblock_type_code - 5'h01);
  wire ac_present_flag = (type_idx >= 5'h0C); // RL14
  wire [4:0] type_rem = ac_present_flag ? (type_idx - 5'h0C) : type_idx;
  wire [1:0] luma_mode = type_rem[1:0]; // RL14
  wire [4:0] nc_full = type_rem >> 2;
  wire [1:0] chroma_pattern = nc_full[1:0]; // RL14
  // one scan order only, so no scan selector exists anywhere
  wire [8:0] coef_expect = ac_present_flag ? (`DC_COUNT + `AC_COUNT) : `DC_COUNT; // RL12 RL13

  // ****************************************
  // 16x16 luma prediction
  // ****************************************
  reg [11:0] sum_above;
  reg [11:0] sum_left;
  reg [12:0] sum_both;
  reg [7:0] dc_val;
  integer h_acc, v_acc, pa, pb, pc, pv;
  reg [7:0] lo_a, lo_l;
  always @* begin
    sum_above = 12'h000;
    sum_left = 12'h000;
    h_acc = 0;
    v_acc = 0;
    for (kl = 0; kl < 16; kl = kl + 1) begin
      sum_above = sum_above + {4'h0, above_mem[kl]}; // RL2
      sum_left = sum_left + {4'h0, left_mem[kl]}; // RL2
    end
    for (kl = 1; kl < 9; kl = kl + 1) begin
      lo_a = (kl == 8) ? corner_reg : above_mem[7 - kl];
      lo_l = (kl == 8) ? corner_reg : left_mem[7 - kl];
      h_acc = h_acc + kl * ($signed({1'b0, above_mem[7 + kl]}) - $signed({1'b0, lo_a})); // RL9
      v_acc = v_acc + kl * ($signed({1'b0, left_mem[7 + kl]}) - $signed({1'b0, lo_l})); // RL9
    end
    pa = 16 * ({24'h000000, left_mem[15]} + {24'h000000, above_mem[15]}); // RL9
    pb = (5 * (h_acc / 4)) / 16; // RL9 RL21
    pc = (5 * (v_acc / 4)) / 16; // RL9 RL21
    sum_both = {1'b0, sum_above} + {1'b0, sum_left};
    case (avail_reg[1:0])
      2'b11: dc_val = sum_both[12:5]; // RL5
      2'b01: dc_val = sum_above[11:4]; // RL6
      2'b10: dc_val = sum_left[11:4]; // RL6
      default: dc_val = `FLAT_SAMPLE; // RL7
    endcase
  end

  // sample at column pi, row pj of the prediction read window
  wire [3:0] pi = s_axi_araddr[5:2];
  wire [3:0] pj = s_axi_araddr[9:6];
  reg [7:0] pred_sample;
  always @* begin
    pv = (pa + pb * ($signed({28'h0000000, pi}) - 7)
          + pc * ($signed({28'h0000000, pj}) - 7) + 16) / 32; // RL8 RL21
    case (luma_mode)
      2'h0: pred_sample = above_mem[pi]; // RL3
      2'h1: pred_sample = left_mem[pj]; // RL4
      2'h2: pred_sample = dc_val;
      default: pred_sample = (pv < 0) ? 8'h00 : (pv > 255) ? 8'hFF : pv[7:0]; // RL8
    endcase
  end

  // ****************************************
  // chroma prediction
  // ****************************************
  // the single chroma mode is fixed, nothing selects it
  reg [7:0] cq_a, cq_b, cq_c, cq_d;
  wire [10:0] s02 = {1'b0, chroma_sum_above_left} + {1'b0, chroma_sum_left_top} + 11'h004;
  wire [10:0] s13 = {1'b0, chroma_sum_above_right} + {1'b0, chroma_sum_left_bottom} + 11'h004;
  wire [10:0] q0 = {1'b0, chroma_sum_above_left} + 11'h002;
  wire [10:0] q1 = {1'b0, chroma_sum_above_right} + 11'h002;
  wire [10:0] q2 = {1'b0, chroma_sum_left_top} + 11'h002;
  wire [10:0] q3 = {1'b0, chroma_sum_left_bottom} + 11'h002;
  always @* begin
    case (avail_reg[3:2]) // RL15
      2'b11: begin
        cq_a = s02[10:3]; // RL16
        cq_b = q1[9:2]; // RL16
        cq_c = q3[9:2]; // RL16
        cq_d = s13[10:3]; // RL16
      end
      2'b01: begin
        cq_a = q0[9:2]; // RL17
        cq_b = q1[9:2]; // RL17
        cq_c = q0[9:2]; // RL17
        cq_d = q1[9:2]; // RL17
      end
      2'b10: begin
        cq_a = q2[9:2]; // RL18
        cq_b = q2[9:2]; // RL18
        cq_c = q3[9:2]; // RL18
        cq_d = q3[9:2]; // RL18
      end
      default: begin
        cq_a = `FLAT_SAMPLE; // RL19
        cq_b = `FLAT_SAMPLE; // RL19
        cq_c = `FLAT_SAMPLE; // RL19
        cq_d = `FLAT_SAMPLE; // RL19
      end
    endcase
  end

  // ****************************************
  // dc level: second transform and scaling
  // ****************************************
  // only the overall dc term of the second transform is exposed; its basis row is flat
  reg signed [31:0] dc_sum;
  reg signed [31:0] dc_out;
  always @* begin
    dc_sum = 32'sh00000000;
    for (kd = 0; kd < 16; kd = kd + 1) begin
      dc_sum = dc_sum + dc_coef[kd]; // RL10
    end
    dc_out = (dc_sum * $signed(`DC_GAIN) * $signed(`DC_SCALE)) >>> `DC_SHIFT; // RL11
  end

  // ****************************************
  // axi4-lite write path
  // ****************************************
  wire do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire [11:0] wa = aw_addr_reg[11:0];
  wire w_hi_ok = (aw_addr_reg[31:12] == 20'h00000);
  wire w_arr = w_hi_ok && (wa[11:7] == 5'h02);
  wire w_reg_hit = w_hi_ok && (wa == `OFS_NEIGH || wa == `OFS_MBTYPE || wa == `OFS_COEF ||
                   wa == `OFS_AVAIL || wa == `OFS_CORNER || wa == `OFS_CSUM_AB ||
                   wa == `OFS_CSUM_LF);
  wire aw_full_next = do_write ? 1'b0 : (aw_full_reg | aw_take);
  wire w_full_next = do_write ? 1'b0 : (w_full_reg | w_take);
  // partial strobes are honoured on the control word only; other registers need a full word
  wire full_word = (w_strb_reg == 4'hF);

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= 32'h00000000;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      neigh_reg <= `NEIGH_RESET;
      macroblock_type_code <= `MBTYPE_RESET;
      avail_reg <= 4'h0;
      corner_reg <= 8'h00;
      chroma_sum_above_left <= 10'h000;
      chroma_sum_above_right <= 10'h000;
      chroma_sum_left_top <= 10'h000;
      chroma_sum_left_bottom <= 10'h000;
      coef_cnt_reg <= 9'h000;
      coef_over_reg <= 1'b0;
      mode_reg <= 4'h0;
      for (k = 0; k < 16; k = k + 1) begin
        above_mem[k] <= 8'h00;
        left_mem[k] <= 8'h00;
        dc_coef[k] <= 16'h0000;
      end
    end else begin
      mode_reg <= mode_next;
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      s_axi_awready <= !aw_full_next;
      s_axi_wready <= !w_full_next;
      if (aw_take) begin
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (w_reg_hit || w_arr) ? `RESP_OKAY : `RESP_SLVERR;
        if (w_hi_ok && wa == `OFS_NEIGH) begin
          for (k = 0; k < 4; k = k + 1) begin
            if (w_strb_reg[k]) begin
              neigh_reg[8*k +: 8] <= w_data_reg[8*k +: 8];
            end
          end
        end
        if (full_word) begin
          if (w_arr && !wa[6]) begin
            above_mem[wa[5:2]] <= w_data_reg[7:0];
          end
          if (w_arr && wa[6]) begin
            left_mem[wa[5:2]] <= w_data_reg[7:0];
          end
          if (w_hi_ok && wa == `OFS_MBTYPE) begin
            macroblock_type_code <= w_data_reg[4:0];
            coef_cnt_reg <= 9'h000;
            coef_over_reg <= 1'b0;
          end
          if (w_hi_ok && wa == `OFS_COEF) begin
            if (coef_cnt_reg < `DC_COUNT) begin
              dc_coef[coef_cnt_reg[3:0]] <= w_data_reg[15:0]; // RL12
            end
            if (coef_cnt_reg < coef_expect) begin
              coef_cnt_reg <= coef_cnt_reg + 9'h001; // RL12
            end else begin
              coef_over_reg <= 1'b1; // RL12
            end
          end
          if (w_hi_ok && wa == `OFS_AVAIL) begin
            avail_reg <= w_data_reg[3:0];
          end
          if (w_hi_ok && wa == `OFS_CORNER) begin
            corner_reg <= w_data_reg[7:0];
          end
          if (w_hi_ok && wa == `OFS_CSUM_AB) begin
            chroma_sum_above_left <= w_data_reg[9:0];
            chroma_sum_above_right <= w_data_reg[25:16];
          end
          if (w_hi_ok && wa == `OFS_CSUM_LF) begin
            chroma_sum_left_top <= w_data_reg[9:0];
            chroma_sum_left_bottom <= w_data_reg[25:16];
          end
        end
      end
    end
  end

  // ****************************************
  // axi4-lite read path
  // ****************************************
  wire [11:0] ra = s_axi_araddr[11:0];
  wire r_hi_ok = (s_axi_araddr[31:12] == 20'h00000);
  reg [31:0] rd_val;
  reg rd_ok;
  always @* begin
    rd_ok = r_hi_ok;
    rd_val = 32'h00000000;
    if (ra[11:10] == 2'b01) begin
      rd_val = {24'h000000, pred_sample};
    end else if (ra[11:7] == 5'h02) begin
      rd_val = {24'h000000, ra[6] ? left_mem[ra[5:2]] : above_mem[ra[5:2]]};
    end else begin
      case (ra)
        `OFS_NEIGH: rd_val = neigh_reg;
        `OFS_MODE: rd_val = {28'h0000000, mode_reg};
        `OFS_MBTYPE: rd_val = {27'h0000000, macroblock_type_code};
        `OFS_STATUS: rd_val = {5'h00, coef_over_reg, (coef_cnt_reg == coef_expect),
                               coef_cnt_reg, 11'h000, chroma_pattern, ac_present_flag,
                               luma_mode};
        `OFS_DC_OUT: rd_val = dc_out;
        `OFS_AVAIL: rd_val = {28'h0000000, avail_reg};
        `OFS_CORNER: rd_val = {24'h000000, corner_reg};
        `OFS_CSUM_AB: rd_val = {6'h00, chroma_sum_above_right, 6'h00, chroma_sum_above_left};
        `OFS_CSUM_LF: rd_val = {6'h00, chroma_sum_left_bottom, 6'h00, chroma_sum_left_top};
        `OFS_CPRED: rd_val = {cq_d, cq_c, cq_b, cq_a};
        default: rd_ok = 1'b0;
      endcase
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_ok ? rd_val : 32'h00000000;
        s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
          s_axi_arready <= 1'b1;
        end
      end else begin
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // intra_pred

// >>> dv/intra_pred_props.sv
// bus-level and result-range assertions of the intra predictor
`timescale 1ns/1ps
`include "intra_pred_map.vh"
module intra_pred_props (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire aw_w = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire ar = s_axi_arvalid && s_axi_arready;
  reg [11:0] ra_reg;
  reg [4:0] mb_reg;
  // remembers what was asked, so read data can be judged by its address
  always @(posedge aclk) begin
    if (!aresetn) mb_reg <= `MBTYPE_RESET;
    else if (aw_w && s_axi_awaddr == `OFS_MBTYPE && s_axi_wstrb == 4'hF) mb_reg <= s_axi_wdata[4:0];
    if (ar) ra_reg <= s_axi_araddr[11:0];
  end
  a_reset_quiet: assert property ($rose(aresetn) |-> !s_axi_awready && !s_axi_bvalid &&
    !s_axi_rvalid) else $error("handshake output active at reset release");
  a_read_latency: assert property (ar |=> s_axi_rvalid) else $error("read answer late");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data moved");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response moved");
  a_write_latency: assert property (aw_w |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  a_unmapped_read: assert property (ar && s_axi_araddr[31:12] != 0 |=>
    s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 0) else $error("unmapped read not refused");
  a_ro_write: assert property (aw_w && s_axi_awaddr == `OFS_MODE |->
    ##[1:2] (s_axi_bvalid && s_axi_bresp == `RESP_SLVERR)) else $error("read-only write accepted");
  a_mode_range: assert property (s_axi_rvalid && ra_reg == `OFS_MODE |-> s_axi_rdata < 9)
    else $error("mode out of list");
  a_status_ac: assert property (s_axi_rvalid && ra_reg == `OFS_STATUS |->
    s_axi_rdata[2] == (mb_reg >= 13)) else $error("ac flag not from type code");
  a_status_full: assert property (s_axi_rvalid && ra_reg == `OFS_STATUS |-> s_axi_rdata[25] ==
    (s_axi_rdata[24:16] == (s_axi_rdata[2] ? 9'h100 : `DC_COUNT))) else $error("count flag wrong");
  a_pred_range: assert property (s_axi_rvalid && ra_reg[11:10] == 2'h1 |-> s_axi_rdata[31:8] == 0)
    else $error("prediction beyond a byte");
  cover property (ar && s_axi_araddr[31:12] != 0);
  cover property (aw_w && s_axi_awaddr == `OFS_COEF);
  cover property (s_axi_rvalid && ra_reg == `OFS_CPRED);
endmodule // intra_pred_props
bind intra_pred intra_pred_props intra_pred_props_inst (.*);

// >>> dv/intra_pred_tb_top.sv
// self-checking bench of the intra predictor over axi4-lite
`timescale 1ns/1ps
`include "intra_pred_map.vh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
  $display("unexpected %0t: got %h want %h", $time, a, b); end end
module intra_pred_tb_top;
  reg aclk = 0;
  reg aresetn = 0;
  reg [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
  reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  wire [3:0] s_axi_wstrb = 4'hF;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int fails = 0, cmp_count = 0, cyc = 0, seed = 90390;
  int ab[16], lf[16], s[4], cor, av, sum, h, i, j;
  int nb[4] = '{0, 'h22, 'h225, 'h330};
  reg [35:0] lst[4] = '{36'h021648573, 36'h287106435, 36'h280174365, 36'h201385476};
  reg [31:0] rd;
  reg [1:0] rs;
  always #5 aclk = ~aclk;
  intra_pred intra_pred_inst (.*);
  // ****************************************
  // bus tasks
  // ****************************************
  task automatic wr(input [31:0] a, input [31:0] d, input [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    while (!s_axi_bvalid) @(posedge aclk);
    `CHK(s_axi_bresp, er)
    s_axi_bready <= 0;
  endtask
  task automatic rdr(input [31:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    while (!s_axi_rvalid) @(posedge aclk);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task automatic rdc(input [31:0] a, input [31:0] e);
    rdr(a);
    `CHK({rs, rd}, {`RESP_OKAY, e})
  endtask
  // ****************************************
  // expectations
  // ****************************************
  function automatic int pred16(int m, int i, int j);
    int a, b, c, p, v;
    if (m == 0) return ab[i];
    if (m == 1) return lf[j];
    sum = 0;
    for (int k = 0; k < 16; k++) sum += (av[0] ? ab[k] : 0) + (av[1] ? lf[k] : 0);
    if (m == 2) return av == 3 ? sum >> 5 : av == 0 ? 128 : sum >> 4;
    h = 0;
    v = 0;
    // the weight-8 tap reaches past the block to the corner sample
    for (int k = 1; k <= 8; k++) begin
      h += k * (ab[7 + k] - (k == 8 ? cor : ab[7 - k]));
      v += k * (lf[7 + k] - (k == 8 ? cor : lf[7 - k]));
    end
    a = 16 * (lf[15] + ab[15]);
    b = 5 * (h / 4) / 16;
    c = 5 * (v / 4) / 16;
    p = (a + b * (i - 7) + c * (j - 7) + 16) / 32;
    return p < 0 ? 0 : p > 255 ? 255 : p;
  endfunction
  function automatic [31:0] cpred(int c);
    int q[4];
    case (c)
      3: q = '{(s[0] + s[2] + 4) / 8, (s[1] + 2) / 4, (s[3] + 2) / 4, (s[1] + s[3] + 4) / 8};
      1: q = '{(s[0] + 2) / 4, (s[1] + 2) / 4, (s[0] + 2) / 4, (s[1] + 2) / 4};
      2: q = '{(s[2] + 2) / 4, (s[2] + 2) / 4, (s[3] + 2) / 4, (s[3] + 2) / 4};
      default: q = '{128, 128, 128, 128};
    endcase
    return {q[3][7:0], q[2][7:0], q[1][7:0], q[0][7:0]};
  endfunction
  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // a hang in any handshake wait ends here
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails++;
      report_and_stop;
    end
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    rdc(`OFS_MBTYPE, 32'h00000001);
    for (int t = 0; t < 4; t++)
      for (int r = 0; r < 9; r++) begin
        wr(`OFS_NEIGH, nb[t] | (r << 16), `RESP_OKAY);
        rdc(`OFS_MODE, lst[t][(8 - r) * 4 +: 4]);
      end
    wr(`OFS_NEIGH, 32'h00011300, `RESP_OKAY);
    rdc(`OFS_MODE, 2);
    for (int k = 0; k < 16; k++) begin
      ab[k] = $random(seed) & 255;
      lf[k] = $random(seed) & 255;
      wr(`OFS_ABOVE + 4 * k, ab[k], `RESP_OKAY);
      wr(`OFS_LEFT + 4 * k, lf[k], `RESP_OKAY);
    end
    cor = $random(seed) & 255;
    wr(`OFS_CORNER, cor, `RESP_OKAY);
    for (int m = 0; m < 4; m++)
      for (int a = 0; a < 4; a++) begin
        if (m != 2 && a != 3) continue;
        av = a;
        wr(`OFS_AVAIL, a, `RESP_OKAY);
        wr(`OFS_MBTYPE, m + 1, `RESP_OKAY);
        rdr(`OFS_STATUS);
        `CHK(rd[2:0], m[2:0])
        for (int n = 0; n < 4; n++) begin
          i = n == 0 ? 0 : n == 1 ? 15 : $random(seed) & 15;
          j = n == 0 ? 0 : n == 1 ? 15 : $random(seed) & 15;
          rdc(`OFS_PRED + 4 * (16 * j + i), pred16(m, i, j));
        end
      end
    wr(`OFS_MBTYPE, 1, `RESP_OKAY);
    sum = 0;
    for (int k = 0; k < 17; k++) begin
      h = $random(seed) % 1000;
      if (k < 16) sum += h;
      wr(`OFS_COEF, h, `RESP_OKAY);
      if (k == 15) rdr(`OFS_STATUS);
    end
    `CHK(rd[26:16], 11'h210)
    rdc(`OFS_DC_OUT, (sum * 169 * 48) >>> 15);
    rdr(`OFS_STATUS);
    `CHK(rd[26], 1'b1)
    wr(`OFS_MBTYPE, 13, `RESP_OKAY);
    repeat (17) wr(`OFS_COEF, 1, `RESP_OKAY);
    rdr(`OFS_STATUS);
    `CHK({rd[26:16], rd[2:0]}, 14'h008C)
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 4; k++) s[k] = $unsigned($random(seed)) % 1021;
      wr(`OFS_CSUM_AB, s[0] | (s[1] << 16), `RESP_OKAY);
      wr(`OFS_CSUM_LF, s[2] | (s[3] << 16), `RESP_OKAY);
      wr(`OFS_AVAIL, c << 2, `RESP_OKAY);
      rdc(`OFS_CPRED, cpred(c));
    end
    wr(`OFS_MODE, 5, `RESP_SLVERR);
    wr(32'h00001000, 0, `RESP_SLVERR);
    rdr(32'h00001000);
    `CHK({rs, rd}, {`RESP_SLVERR, 32'h00000000})
    report_and_stop;
  end
endmodule // intra_pred_tb_top
